// File: logic/tnv_pkg.sv
package tnv_pkg;
	localparam int ADDR_W = 19;
	localparam int DATA_W = 8;
	localparam int RTC_REGS = 16;
	// the sixteen top byte addresses share this upper address value
	localparam logic [14:0] RTC_PAGE = 15'h7FFF;

	localparam logic [3:0] OFS_FLAGS = 4'h0;
	localparam logic [3:0] OFS_UNUSED = 4'h1;
	localparam logic [3:0] OFS_ALM_SEC = 4'h2;
	localparam logic [3:0] OFS_ALM_MIN = 4'h3;
	localparam logic [3:0] OFS_ALM_HOUR = 4'h4;
	localparam logic [3:0] OFS_ALM_DATE = 4'h5;
	localparam logic [3:0] OFS_INTR = 4'h6;
	localparam logic [3:0] OFS_WDOG = 4'h7;
	localparam logic [3:0] OFS_CTRL = 4'h8;
	localparam logic [3:0] OFS_SEC = 4'h9;
	localparam int TIME_BASE = 8;

	// timekeeping set index = byte offset minus TIME_BASE
	localparam int TK_CENT = 0;
	localparam int TK_SEC = 1;
	localparam int TK_MIN = 2;
	localparam int TK_HOUR = 3;
	localparam int TK_DAY = 4;
	localparam int TK_DATE = 5;
	localparam int TK_MONTH = 6;
	localparam int TK_YEAR = 7;

	localparam int CTRL_W_BIT = 7;
	localparam int CTRL_R_BIT = 6;
	localparam int OSC_BIT = 7;
	localparam int WDS_BIT = 7;
	localparam int BMB_MSB = 6;
	localparam int BMB_LSB = 2;
	localparam int AE_BIT = 7;
	localparam int ABE_BIT = 5;
	localparam int AM_BIT = 7;
	localparam int WF_BIT = 7;
	localparam int AF_BIT = 6;
	localparam int BLF_BIT = 4;

	localparam logic [7:0] FIELD_MASK [0:7] = '{8'h3F, 8'h7F, 8'h7F,
		8'h3F, 8'h07, 8'h3F, 8'h1F, 8'hFF};
	localparam logic [7:0] TK_RESET [0:7] = '{8'h20, 8'h00, 8'h00,
		8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
	localparam logic [7:0] BCD_ZERO = 8'h00;
	localparam logic [7:0] BCD_ONE = 8'h01;
	localparam logic [7:0] SEC_MAX = 8'h59;
	localparam logic [7:0] MIN_MAX = 8'h59;
	localparam logic [7:0] HOUR_MAX = 8'h23;
	localparam logic [7:0] DAY_MAX = 8'h07;
	localparam logic [7:0] MONTH_MAX = 8'h12;
	localparam logic [7:0] YEAR_MAX = 8'h99;
	localparam logic [7:0] CENT_MAX = 8'h39;
	localparam logic [7:0] CENT_NOLEAP = 8'h21;

	localparam int CLK_PERIOD_NS = 4;
	localparam int TICK16_NS = 62_500_000;
	localparam int TICK16_CYCLES = TICK16_NS / CLK_PERIOD_NS;
	localparam logic [3:0] TICKS_PER_SEC_M1 = 4'hF;
	localparam int POR_MIN_MS = 40;
	localparam int POR_MAX_MS = 200;
	localparam int POR_CYCLES = (POR_MIN_MS * 1_000_000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	// watchdog resolution in sixteenth-second ticks: 1/16, 1/4, 1, 4 s
	localparam logic [10:0] WD_RES_TICKS [0:3] = '{11'h001, 11'h004,
		11'h010, 11'h040};

	typedef struct packed {
		logic chip_sel_n;
		logic out_en_n;
		logic write_en_n;
		logic [ADDR_W-1:0] address_lines;
		logic [DATA_W-1:0] data_lines;
	} tnv_bus_s;

	typedef struct packed {
		logic supply_ok;
		logic on_battery;
		logic battery_low;
	} tnv_pwr_s;
endpackage

// File: logic/tnv_ram.sv
`timescale 1ns/10ps
module tnv_ram import tnv_pkg::*; (
	// clock
	input wire logic core_clk,
	input wire logic clk_en,
	// access
	input wire logic wr,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	output logic [DATA_W-1:0] rdata
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	always_ff @(posedge core_clk) begin
		if (clk_en) begin
			if (wr) begin
				mem[addr] <= wdata;
			end
			rdata <= mem[addr];
		end
	end
endmodule // tnv_ram

// File: logic/tnv_bus_rtc.sv
`timescale 1ns/10ps
module tnv_bus_rtc import tnv_pkg::*; #(
	parameter int TICK16_CYC = TICK16_CYCLES,
	parameter int POR_CYC = POR_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic clk_en,
	// memory bus
	input wire tnv_bus_s bus,
	output logic [DATA_W-1:0] data_lines_out,
	output logic data_lines_oe,
	// supply monitor
	input wire tnv_pwr_s pwr,
	// open-drain outputs
	output logic interrupt_test_out_n_out,
	output logic interrupt_test_out_n_oe,
	output logic reset_out_n_out,
	output logic reset_out_n_oe
);
	logic rtc_hit;
	logic [3:0] idx;
	logic rd_sel;
	logic wr_sel;
	logic wr_rtc;
	logic [DATA_W-1:0] user [0:RTC_REGS-1];
	logic [7:0] tk [0:7];
	logic [7:0] next_tk [0:7];
	logic freeze;
	logic w_q;
	logic load_user;
	logic osc_stop;
	logic [23:0] pre_cnt;
	logic [3:0] sub16;
	logic tick16;
	logic sec_tick;
	logic [8:0] c;
	logic [8:0] d;
	logic leap;
	logic alarm_hit;
	logic [7:0] wd_cfg;
	logic [10:0] wd_load;
	logic [10:0] wd_cnt;
	logic wd_kick;
	logic wd_expire;
	logic wf;
	logic af;
	logic rd_flags;
	logic rd_flags_q;
	logic flags_clr;
	logic [23:0] por_cnt;
	logic [DATA_W-1:0] reg_q;
	logic [DATA_W-1:0] ram_q;
	logic hit_q;
	logic irq_act;

	function automatic logic [8:0] bcd_inc(input logic [7:0] v,
		input logic [7:0] max, input logic [7:0] min);
		// out-of-range garbage written by software also wraps
		if (v >= max) begin
			return {1'b1, min};
		end else if (v[3:0] >= 4'h9) begin
			return {1'b0, v[7:4] + 4'h1, 4'h0};
		end else begin
			return {1'b0, v[7:4], v[3:0] + 4'h1};
		end
	endfunction

	function automatic logic alm_ok(input logic [7:0] a,
		input logic [7:0] t, input logic [7:0] m);
		return a[AM_BIT] | ((a & m & 8'h7F) == (t & m & 8'h7F));
	endfunction

	// bus decode
	assign rtc_hit = bus.address_lines[ADDR_W-1:4] == RTC_PAGE;
	assign idx = bus.address_lines[3:0];
	assign rd_sel = pwr.supply_ok & !bus.chip_sel_n
		& bus.write_en_n;
	assign wr_sel = pwr.supply_ok & !bus.chip_sel_n
		& !bus.write_en_n;
	assign wr_rtc = wr_sel & rtc_hit;
	assign data_lines_oe = rd_sel & !bus.out_en_n;

	tnv_ram u_ram (
		.core_clk(core_clk),
		.clk_en(clk_en),
		.wr(wr_sel & !rtc_hit),
		.addr(bus.address_lines),
		.wdata(bus.data_lines),
		.rdata(ram_q)
	);

	// read path: one registered access per cycle on the live address
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			reg_q <= 8'h00;
			hit_q <= 1'b0;
		end else if (clk_en) begin
			hit_q <= rtc_hit;
			if (idx == OFS_FLAGS) begin
				reg_q <= {wf, af, 1'b0, pwr.battery_low,
					4'h0};
			end else begin
				reg_q <= user[idx];
			end
		end
	end
	// old byte stays one cycle after an address change
	assign data_lines_out = hit_q ? reg_q : ram_q;

	// freeze and write-back of the visible set
	assign freeze = user[OFS_CTRL][CTRL_W_BIT]
		| user[OFS_CTRL][CTRL_R_BIT];
	assign load_user = w_q & !user[OFS_CTRL][CTRL_W_BIT];
	assign osc_stop = user[OFS_SEC][OSC_BIT];

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			w_q <= 1'b0;
		end else if (clk_en) begin
			w_q <= user[OFS_CTRL][CTRL_W_BIT];
		end
	end

	for (genvar g = 0; g < RTC_REGS; g++) begin : g_reg
		if (g >= TIME_BASE) begin : g_time
			always_ff @(posedge core_clk) begin
				if (!nrst) begin
					user[g] <= TK_RESET[g-TIME_BASE];
				end else if (clk_en) begin
					if (wr_rtc && idx == 4'(g)) begin
						user[g] <= bus.data_lines;
					end else if (!freeze && !load_user) begin
						user[g] <= (user[g] & ~FIELD_MASK[g-TIME_BASE])
							| (tk[g-TIME_BASE] & FIELD_MASK[g-TIME_BASE]);
					end
				end
			end
		end else begin : g_plain
			always_ff @(posedge core_clk) begin
				if (!nrst) begin
					user[g] <= 8'h00;
				end else if (clk_en && wr_rtc && idx == 4'(g)) begin
					user[g] <= bus.data_lines;
				end
			end
		end
	end

	// time base
	assign tick16 = pre_cnt == 24'(TICK16_CYC - 1);
	assign sec_tick = tick16 & (sub16 == TICKS_PER_SEC_M1) & !osc_stop;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			pre_cnt <= 24'h00_0000;
			sub16 <= 4'h0;
		end else if (clk_en) begin
			if (tick16) begin
				pre_cnt <= 24'h00_0000;
				sub16 <= sub16 + 4'h1;
			end else begin
				pre_cnt <= pre_cnt + 24'h00_0001;
			end
		end
	end

	// leap year: BCD year divisible by four, 2100 excluded
	always_comb begin
		if (tk[TK_YEAR][4]) begin
			leap = tk[TK_YEAR][3:0] == 4'h2 || tk[TK_YEAR][3:0] == 4'h6;
		end else begin
			leap = tk[TK_YEAR][3:0] == 4'h0 || tk[TK_YEAR][3:0] == 4'h4
				|| tk[TK_YEAR][3:0] == 4'h8;
		end
		if (tk[TK_YEAR] == BCD_ZERO && tk[TK_CENT] == CENT_NOLEAP) begin
			leap = 1'b0;
		end
	end

	always_comb begin
		logic [7:0] dmax;
		dmax = 8'h31;
		c = 9'h000;
		d = 9'h000;
		next_tk = tk;
		case (tk[TK_MONTH])
			8'h02: dmax = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: dmax = 8'h30;
			default: dmax = 8'h31;
		endcase
		if (load_user) begin
			for (int i = 0; i < 8; i++) begin
				next_tk[i] = user[i+TIME_BASE] & FIELD_MASK[i];
			end
		end else if (sec_tick) begin
			c = bcd_inc(tk[TK_SEC], SEC_MAX, BCD_ZERO);
			next_tk[TK_SEC] = c[7:0];
			if (c[8]) begin
				c = bcd_inc(tk[TK_MIN], MIN_MAX, BCD_ZERO);
				next_tk[TK_MIN] = c[7:0];
			end
			if (c[8]) begin
				c = bcd_inc(tk[TK_HOUR], HOUR_MAX, BCD_ZERO);
				next_tk[TK_HOUR] = c[7:0];
			end
			if (c[8]) begin
				d = bcd_inc(tk[TK_DAY], DAY_MAX, BCD_ONE);
				next_tk[TK_DAY] = d[7:0];
				c = bcd_inc(tk[TK_DATE], dmax, BCD_ONE);
				next_tk[TK_DATE] = c[7:0];
			end
			if (c[8]) begin
				c = bcd_inc(tk[TK_MONTH], MONTH_MAX, BCD_ONE);
				next_tk[TK_MONTH] = c[7:0];
			end
			if (c[8]) begin
				c = bcd_inc(tk[TK_YEAR], YEAR_MAX, BCD_ZERO);
				next_tk[TK_YEAR] = c[7:0];
			end
			if (c[8]) begin
				c = bcd_inc(tk[TK_CENT], CENT_MAX, BCD_ZERO);
				next_tk[TK_CENT] = c[7:0];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			tk <= TK_RESET;
		end else if (clk_en) begin
			tk <= next_tk;
		end
	end

	// alarm compare on the value the second rolls into
	assign alarm_hit = sec_tick
		& alm_ok(user[OFS_ALM_SEC], next_tk[TK_SEC], FIELD_MASK[TK_SEC])
		& alm_ok(user[OFS_ALM_MIN], next_tk[TK_MIN], FIELD_MASK[TK_MIN])
		& alm_ok(user[OFS_ALM_HOUR], next_tk[TK_HOUR], FIELD_MASK[TK_HOUR])
		& alm_ok(user[OFS_ALM_DATE], next_tk[TK_DATE],
			FIELD_MASK[TK_DATE]);

	// watchdog, reloaded by every write cycle to its byte
	assign wd_kick = wr_rtc & (idx == OFS_WDOG);
	assign wd_cfg = wd_kick ? bus.data_lines : user[OFS_WDOG];
	assign wd_load = 11'(wd_cfg[BMB_MSB:BMB_LSB])
		* WD_RES_TICKS[wd_cfg[1:0]];
	assign wd_expire = tick16 & !osc_stop & pwr.supply_ok
		& (wd_cnt == 11'h001) & !wd_kick;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			wd_cnt <= 11'h000;
		end else if (clk_en) begin
			if (wd_kick || wd_expire) begin
				wd_cnt <= wd_load;
			end else if (tick16 && !osc_stop && wd_cnt != 11'h000) begin
				wd_cnt <= wd_cnt - 11'h001;
			end
		end
	end

	// flags clear when a read of them ends, a new event wins
	assign rd_flags = rd_sel & rtc_hit & (idx == OFS_FLAGS);
	assign flags_clr = rd_flags_q & !rd_flags;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rd_flags_q <= 1'b0;
			af <= 1'b0;
			wf <= 1'b0;
		end else if (clk_en) begin
			rd_flags_q <= rd_flags;
			if (alarm_hit) begin
				af <= 1'b1;
			end else if (flags_clr) begin
				af <= 1'b0;
			end
			if (wd_expire) begin
				wf <= 1'b1;
			end else if (flags_clr) begin
				wf <= 1'b0;
			end
		end
	end

	// power-on reset stretch, also restarted by a watchdog reset
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			por_cnt <= 24'(POR_CYC);
		end else if (clk_en) begin
			if (!pwr.supply_ok
				|| (wd_expire && wd_cfg[WDS_BIT])) begin
				por_cnt <= 24'(POR_CYC);
			end else if (por_cnt != 24'h00_0000) begin
				por_cnt <= por_cnt - 24'h00_0001;
			end
		end
	end

	assign irq_act = (af & user[OFS_INTR][AE_BIT]
		& (!pwr.on_battery | user[OFS_INTR][ABE_BIT]))
		| (wf & !user[OFS_WDOG][WDS_BIT]);

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			interrupt_test_out_n_oe <= 1'b0;
			reset_out_n_oe <= 1'b1;
		end else if (clk_en) begin
			interrupt_test_out_n_oe <= irq_act;
			reset_out_n_oe <= !pwr.supply_ok
				|| por_cnt != 24'h00_0000;
		end
	end
	// open drain: only ever pulls low
	assign interrupt_test_out_n_out = 1'b0;
	assign reset_out_n_out = 1'b0;
endmodule // tnv_bus_rtc

// File: sim/tnv_bus_rtc_monitor.sv
`timescale 1ns/10ps
module tnv_bus_rtc_monitor import tnv_pkg::*; #(
	parameter int POR_CYC = POR_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic clk_en,
	// bus and supply
	input wire tnv_bus_s bus,
	input wire logic [DATA_W-1:0] data_lines_out,
	input wire logic data_lines_oe,
	input wire tnv_pwr_s pwr,
	// open-drain outputs
	input wire logic interrupt_test_out_n_out,
	input wire logic interrupt_test_out_n_oe,
	input wire logic reset_out_n_out,
	input wire logic reset_out_n_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	logic rd;
	logic top;
	int ok_cnt;
	assign rd = pwr.supply_ok & !bus.chip_sel_n & bus.write_en_n;
	assign top = bus.address_lines[18:4] == RTC_PAGE;
	// saturates, only the release moment matters
	always_ff @(posedge core_clk) begin
		if (!nrst || !pwr.supply_ok) begin
			ok_cnt <= 0;
		end else if (ok_cnt < POR_CYC) begin
			ok_cnt <= ok_cnt + 1;
		end
	end
	property p_oe_map;
		data_lines_oe == (pwr.supply_ok && !bus.chip_sel_n &&
			!bus.out_en_n && bus.write_en_n);
	endproperty
	a_oe_map: assert property (p_oe_map)
		else $error("drive mismatch");
	property p_idle;
		bus.chip_sel_n || (bus.out_en_n && bus.write_en_n) |-> !data_lines_oe;
	endproperty
	a_idle: assert property (p_idle)
		else $error("idle drive");
	property p_pf_off;
		!pwr.supply_ok |-> !data_lines_oe;
	endproperty
	a_pf_off: assert property (p_pf_off)
		else $error("drive in fail");
	property p_rst_fail;
		!pwr.supply_ok |=> reset_out_n_oe;
	endproperty
	a_rst_fail: assert property (p_rst_fail)
		else $error("no reset");
	property p_rst_hold;
		$rose(pwr.supply_ok) |-> reset_out_n_oe [*8];
	endproperty
	a_rst_hold: assert property (p_rst_hold)
		else $error("short reset");
	property p_rst_rel;
		$fell(reset_out_n_oe) |-> ok_cnt >= POR_CYC - 2;
	endproperty
	a_rst_rel: assert property (p_rst_rel)
		else $error("early release");
	property p_ripple;
		rd && !top ##1 rd && $stable(bus) |=> $stable(data_lines_out);
	endproperty
	a_ripple: assert property (p_ripple)
		else $error("read moved");
	property p_old_byte;
		rd && !top && $stable(bus.address_lines) ##1
			rd && $changed(bus.address_lines) |-> $stable(data_lines_out);
	endproperty
	a_old_byte: assert property (p_old_byte)
		else $error("no hold");
	property p_flags;
		rd && bus.address_lines == {RTC_PAGE, OFS_FLAGS} |=>
			data_lines_out[BLF_BIT] == $past(pwr.battery_low) &&
			data_lines_out[5] == 1'b0 && data_lines_out[3:0] == 4'h0;
	endproperty
	a_flags: assert property (p_flags)
		else $error("bad flags");
	cover property (rd && top);
	cover property ($rose(interrupt_test_out_n_oe));
	cover property ($fell(reset_out_n_oe));
endmodule // tnv_bus_rtc_monitor
bind tnv_bus_rtc tnv_bus_rtc_monitor #(.POR_CYC(POR_CYC)) u_mon (
	.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .bus(bus),
	.data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
	.pwr(pwr), .interrupt_test_out_n_out(interrupt_test_out_n_out),
	.interrupt_test_out_n_oe(interrupt_test_out_n_oe),
	.reset_out_n_out(reset_out_n_out), .reset_out_n_oe(reset_out_n_oe));

// File: sim/tnv_host.sv
`timescale 1ns/10ps
module tnv_host import tnv_pkg::*; (
	// clock
	input wire logic core_clk,
	// resolved data wire and strobes
	input wire logic [DATA_W-1:0] dq,
	output tnv_bus_s bus
);
	logic [7:0] last = 8'h00;
	initial bus = {3'b111, 19'h0_0000, 8'hFF};
	// address held through the whole write, data inverted once released
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus <= {3'b010, a, d};
		@(posedge core_clk);
		bus <= {3'b111, a, ~d};
	endtask
	// select stays low so the next read ripples on a new address
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
		@(posedge core_clk);
		bus <= {3'b001, a, ~last};
		@(posedge core_clk);
		@(negedge core_clk);
		d = dq;
		last = d;
	endtask
endmodule // tnv_host

// File: sim/tnv_bus_rtc_tb.sv
`timescale 1ns/10ps
`define CK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
	$display("ERROR %0t %h %h", $time, a, b); end end
module tnv_bus_rtc_tb import tnv_pkg::*;;
	localparam int POR = 20;
	localparam int CAL [5][4] = '{'{20, 0, 2, 28}, '{20, 1, 2, 28},
		'{20, 99, 12, 31}, '{21, 0, 2, 28}, '{20, 1, 4, 30}};
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	tnv_pwr_s pwr = 3'b100;
	tnv_bus_s hb, bw;
	logic [7:0] dout, rv;
	logic doe, irq, rst, iro, rso;
	int fails = 0;
	int checks_done = 0;
	logic [31:0] seed = 32'ha7d6;
	logic [7:0] mem [int];
	always #2 core_clk = ~core_clk;
	assign bw = doe ? {hb[29:8], dout} : hb;
	tnv_host host (.core_clk(core_clk), .dq(bw.data_lines), .bus(hb));
	tnv_bus_rtc #(.TICK16_CYC(4), .POR_CYC(POR)) dut (.core_clk(core_clk),
		.nrst(nrst), .clk_en(1'b1), .bus(bw), .data_lines_out(dout),
		.data_lines_oe(doe), .pwr(pwr), .interrupt_test_out_n_out(iro),
		.interrupt_test_out_n_oe(irq), .reset_out_n_out(rso),
		.reset_out_n_oe(rst));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] bcd(input int i);
		return 8'((i / 10) * 16 + i % 10);
	endfunction
	function automatic logic [18:0] ra(input int o);
		return {RTC_PAGE, 4'(o)};
	endfunction
	task automatic wrap_up();
		if (fails == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic wt(ref logic s, input logic v, input int n, output int k);
		k = 0;
		while (s !== v && k < n) begin
			@(posedge core_clk);
			k++;
		end
		if (s !== v) begin
			fails++;
			wrap_up();
		end
	endtask
	task automatic cal_case(input int c, y, m, d);
		int dim, full, ec, ey, em, ed, k;
		full = c * 100 + y;
		dim = (m == 4 || m == 6 || m == 9 || m == 11) ? 30 : 31;
		if (m == 2) dim = (full % 4 == 0 && (full % 100 != 0 ||
			full % 400 == 0)) ? 29 : 28;
		ec = c;
		ey = y;
		em = m;
		ed = d + 1;
		if (ed > dim) begin
			ed = 1;
			em++;
		end
		if (em > 12) begin
			em = 1;
			ey++;
		end
		if (ey > 99) begin
			ey = 0;
			ec++;
		end
		host.wr(ra(8), 8'h80 | bcd(c));
		host.wr(ra(9), 8'h59);
		host.wr(ra(10), 8'h59);
		host.wr(ra(11), 8'h23);
		host.wr(ra(13), bcd(d));
		host.wr(ra(14), bcd(m));
		host.wr(ra(15), bcd(y));
		host.wr(ra(8), bcd(c));
		for (k = 0; k < 100; k++) begin
			host.rd(ra(9), rv);
			if (rv !== 8'h59) break;
		end
		`CK(rv, 8'h00)
		// century read before the freeze write so a rollover is not lost
		host.rd(ra(8), rv);
		`CK(rv[5:0], 6'(bcd(ec)))
		host.wr(ra(8), 8'h40 | rv);
		host.rd(ra(11), rv);
		`CK(rv, 8'h00)
		host.rd(ra(13), rv);
		`CK(rv, bcd(ed))
		host.rd(ra(14), rv);
		`CK(rv, bcd(em))
		host.rd(ra(15), rv);
		`CK(rv, bcd(ey))
		repeat (100) @(posedge core_clk);
		host.rd(ra(9), rv);
		`CK(rv, 8'h00)
	endtask
	initial begin
		int i, k;
		logic [18:0] a;
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		`CK({iro, rso}, 2'b00)
		for (i = 0; i < 24; i++) begin
			a = {11'h000, 8'(xs())};
			mem[a] = 8'(xs());
			host.wr(a, mem[a]);
		end
		foreach (mem[j]) begin
			host.rd(19'(j), rv);
			`CK(rv, mem[j])
		end
		@(posedge core_clk);
		pwr.supply_ok <= 1'b0;
		host.wr(a, ~mem[a]);
		`CK(rst, 1'b1)
		@(posedge core_clk);
		pwr.supply_ok <= 1'b1;
		wt(rst, 1'b0, POR + 10, k);
		`CK(1'(k >= POR - 1 && k <= POR + 2), 1'b1)
		host.rd(a, rv);
		`CK(rv, mem[a])
		host.wr(ra(0), 8'hFF);
		for (i = 0; i < 2; i++) begin
			@(posedge core_clk);
			pwr.battery_low <= 1'(i);
			host.rd(ra(0), rv);
			`CK(rv & 8'h3F, 8'(i << BLF_BIT))
		end
		for (i = 2; i < 6; i++) host.wr(ra(i), 8'h80);
		host.wr(ra(6), 8'h80);
		wt(irq, 1'b1, 200, k);
		@(posedge core_clk);
		pwr.on_battery <= 1'b1;
		repeat (3) @(posedge core_clk);
		`CK(irq, 1'b0)
		host.wr(ra(6), 8'hA0);
		repeat (3) @(posedge core_clk);
		`CK(irq, 1'b1)
		pwr.on_battery <= 1'b0;
		host.wr(ra(6), 8'h00);
		host.rd(ra(0), rv);
		host.wr(ra(7), 8'h04);
		wt(irq, 1'b1, 40, k);
		host.wr(ra(7), 8'h84);
		wt(rst, 1'b1, 40, k);
		host.wr(ra(7), 8'h00);
		wt(rst, 1'b0, POR + 40, k);
		host.rd(ra(0), rv);
		for (i = 0; i < 5; i++) cal_case(CAL[i][0], CAL[i][1], CAL[i][2],
			CAL[i][3]);
		wrap_up();
	end
endmodule // tnv_bus_rtc_tb
